// >>> verilog/dpa_pkg.sv
// Register map, field positions and encodings for the port, audio and colour registers
package dpa_pkg;
  localparam logic [7:0] ADDR_COLOR_BALANCE = 8'h2a;
  localparam logic [7:0] ADDR_AUDIO_SERIAL  = 8'h2b;
  localparam logic [7:0] ADDR_PIXEL_CLOCK   = 8'h2e;
  localparam logic [7:0] ADDR_DUAL_RECEIVE  = 8'h34;
  localparam logic [7:0] ADDR_EQUALIZER     = 8'h35;
  localparam logic [7:0] RST_COLOR_BALANCE  = 8'h00;
  localparam logic [7:0] RST_AUDIO_SERIAL   = 8'h00;
  localparam logic [7:0] RST_PIXEL_CLOCK    = 8'h00;
  localparam logic [7:0] RST_DUAL_RECEIVE   = 8'h01;
  localparam logic [7:0] RST_EQUALIZER      = 8'h00;
  // Writable masks; all other bits are reserved and read zero, except the audio overrun and underrun status bits and the write-only audio error clear bit
  localparam logic [7:0] WMASK_COLOR_BALANCE = 8'hf0;
  localparam logic [7:0] WMASK_AUDIO_SERIAL  = 8'h01;
  localparam logic [7:0] WMASK_PIXEL_CLOCK   = 8'h80;
  localparam logic [7:0] WMASK_DUAL_RECEIVE  = 8'h7b;
  localparam logic [7:0] WMASK_EQUALIZER     = 8'h70;
  // Field positions
  localparam int PAGE_HI        = 7;
  localparam int PAGE_LO        = 6;
  localparam int COLOR_EN_BIT   = 5;
  localparam int REFRESH_BIT    = 4;
  localparam int OVERRUN_BIT    = 3;
  localparam int UNDERRUN_BIT   = 2;
  localparam int ERR_CLEAR_BIT  = 1;
  localparam int RISE_EDGE_BIT  = 0;
  localparam int EXT_PCLK_BIT   = 7;
  localparam int LOCK_MODE_BIT  = 6;
  localparam int RAW_AUX_BIT    = 5;
  localparam int INMODE_HI      = 4;
  localparam int INMODE_LO      = 3;
  localparam int SECOND_SEL_BIT = 1;
  localparam int FIRST_SEL_BIT  = 0;
  localparam int EQ_HI          = 6;
  localparam int EQ_LO          = 4;
  localparam logic [7:0] READ_ZERO = 8'h00;
  typedef enum logic [1:0] {
    DPA_PAGE_CONFIG,
    DPA_PAGE_RED,
    DPA_PAGE_GREEN,
    DPA_PAGE_BLUE
  } dpa_page_t;
  typedef enum logic [1:0] {
    DPA_IN_AUTO,
    DPA_IN_DUAL,
    DPA_IN_PRIMARY,
    DPA_IN_SECONDARY
  } dpa_input_mode_t;
endpackage : dpa_pkg

// >>> verilog/dpa_sync2.sv
// Two-flop synchroniser for pins from outside the core clock domain
`timescale 1ns/1ps
module dpa_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         core_clk_in,
  input  wire logic         rst_n_in,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end
  assign sync_out = sync_reg;
endmodule : dpa_sync2

// >>> verilog/dpa_regs.sv
// Port, audio and colour configuration/status register group
`timescale 1ns/1ps
module dpa_regs
  import dpa_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       arst_n_in,
  // Register port from the serial control slave
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic      [7:0] reg_rdata_out,
  // Audio FIFO event pulses, same clock
  input  wire logic       fifo_overrun_in,
  input  wire logic       fifo_underrun_in,
  // Link status, same clock
  input  wire logic       link_up_in,
  input  wire logic       video_off_in,
  // Pins from outside the domain
  input  wire logic       return_gpio_zero_in,
  input  wire logic       selftest_clock_pin_in,
  input  wire logic       recovered_clk_in,
  // Filtered return path from the back-channel sampler
  input  wire logic       return_filtered_in,
  // Pixel data
  input  wire logic [7:0] pix_red_in,
  input  wire logic [7:0] pix_green_in,
  input  wire logic [7:0] pix_blue_in,
  output logic      [7:0] pix_red_out,
  output logic      [7:0] pix_green_out,
  output logic      [7:0] pix_blue_out,
  // Control outputs
  output logic      [1:0] page_out,
  output logic            table_refresh_allow_out,
  output logic            audio_rise_edge_out,
  output logic            pixel_clk_sel_out,
  output logic            pixel_clk_out,
  output logic            rx_lock_out,
  output logic            video_enable_out,
  output logic            raw_aux_return_path_out,
  output logic            aux_return_out,
  output logic      [1:0] serial_input_mode_out,
  output logic            second_port_access_out,
  output logic            first_port_access_out,
  output logic      [2:0] adaptive_equalizer_p0_out,
  output logic      [2:0] adaptive_equalizer_p1_out
);
  // Reset release through two flops
  logic rst_sync1_reg;
  logic rst_n;
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync1_reg <= 1'b0;
      rst_n         <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_n         <= rst_sync1_reg;
    end
  end

  // Pins synchronised before use
  logic [2:0] pins_sync;
  dpa_sync2 #(.W(3)) u_sync (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n),
    .async_in    ({return_gpio_zero_in, selftest_clock_pin_in, recovered_clk_in}),
    .sync_out    (pins_sync)
  );
  wire gpio0_sync   = pins_sync[2];
  wire selftest_sync = pins_sync[1];
  wire recov_sync   = pins_sync[0];

  // Registers
  logic [7:0] color_balance_ctrl_reg;
  logic [7:0] audio_serial_ctrl_reg;
  logic [7:0] pixel_clock_test_reg;
  logic [7:0] dual_receive_ctrl_reg;
  logic [7:0] equalizer_test_p0_reg;
  logic [7:0] equalizer_test_p1_reg;
  logic       overrun_reg;
  logic       underrun_reg;
  logic [7:0] lut_mem [3][256];

  // One compare serves both the write strobes and the read mux
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction : addr_is

  // Address decoding
  wire hit_color  = addr_is(reg_addr_in, ADDR_COLOR_BALANCE);
  wire hit_audio  = addr_is(reg_addr_in, ADDR_AUDIO_SERIAL);
  wire hit_pclk   = addr_is(reg_addr_in, ADDR_PIXEL_CLOCK);
  wire hit_dual   = addr_is(reg_addr_in, ADDR_DUAL_RECEIVE);
  wire hit_eq     = addr_is(reg_addr_in, ADDR_EQUALIZER);
  wire page_cfg   = (color_balance_ctrl_reg[PAGE_HI:PAGE_LO] == DPA_PAGE_CONFIG);
  wire page_lut   = !page_cfg;
  wire [1:0] lut_idx = color_balance_ctrl_reg[PAGE_HI:PAGE_LO] - 2'd1;
  // The page field itself stays reachable from any page, otherwise software
  // could never return to configuration space
  wire cfg_access = page_cfg || hit_color;
  wire wr_color   = reg_wr_in && hit_color;
  wire wr_audio   = reg_wr_in && cfg_access && hit_audio;
  wire wr_pclk    = reg_wr_in && cfg_access && hit_pclk;
  wire wr_dual    = reg_wr_in && cfg_access && hit_dual;
  wire wr_eq      = reg_wr_in && cfg_access && hit_eq;
  wire sel_p1     = dual_receive_ctrl_reg[SECOND_SEL_BIT];
  wire sel_p0     = dual_receive_ctrl_reg[FIRST_SEL_BIT];
  wire wr_eq_p0   = wr_eq && sel_p0;
  wire wr_eq_p1   = wr_eq && sel_p1;
  wire err_clear  = wr_audio && reg_wdata_in[ERR_CLEAR_BIT];
  wire refresh_ok = color_balance_ctrl_reg[REFRESH_BIT];
  wire wr_lut     = reg_wr_in && page_lut && !hit_color && refresh_ok;

  // Masks keep reserved bits at zero whatever is written
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      color_balance_ctrl_reg <= RST_COLOR_BALANCE;
    end else if (wr_color) begin
      color_balance_ctrl_reg <= reg_wdata_in & WMASK_COLOR_BALANCE;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      audio_serial_ctrl_reg <= RST_AUDIO_SERIAL;
    end else if (wr_audio) begin
      audio_serial_ctrl_reg <= reg_wdata_in & WMASK_AUDIO_SERIAL;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pixel_clock_test_reg <= RST_PIXEL_CLOCK;
    end else if (wr_pclk) begin
      pixel_clock_test_reg <= reg_wdata_in & WMASK_PIXEL_CLOCK;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      dual_receive_ctrl_reg <= RST_DUAL_RECEIVE;
    end else if (wr_dual) begin
      dual_receive_ctrl_reg <= reg_wdata_in & WMASK_DUAL_RECEIVE;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      equalizer_test_p0_reg <= RST_EQUALIZER;
    end else if (wr_eq_p0) begin
      equalizer_test_p0_reg <= reg_wdata_in & WMASK_EQUALIZER;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      equalizer_test_p1_reg <= RST_EQUALIZER;
    end else if (wr_eq_p1) begin
      equalizer_test_p1_reg <= reg_wdata_in & WMASK_EQUALIZER;
    end
  end

  // Sticky FIFO errors; a new event wins over a clear in the same cycle
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      overrun_reg <= 1'b0;
    end else begin
      overrun_reg <= fifo_overrun_in | (overrun_reg & ~err_clear);
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      underrun_reg <= 1'b0;
    end else begin
      underrun_reg <= fifo_underrun_in | (underrun_reg & ~err_clear);
    end
  end

  // Colour tables, no reset: contents are loaded by software
  always_ff @(posedge core_clk_in) begin
    if (wr_lut) lut_mem[lut_idx][reg_addr_in] <= reg_wdata_in;
  end

  // Colour correction stage, one cycle of latency either way
  wire       color_en = color_balance_ctrl_reg[COLOR_EN_BIT];
  wire [7:0] pix_in_arr [3];
  assign pix_in_arr[0] = pix_red_in;
  assign pix_in_arr[1] = pix_green_in;
  assign pix_in_arr[2] = pix_blue_in;
  // Table c belongs to channel c, so one loop covers all three colours
  for (genvar c = 0; c < 3; c++) begin : g_chan
    logic [7:0] chan_reg;
    always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
        chan_reg <= 8'h00;
      end else begin
        chan_reg <= color_en ? lut_mem[c][pix_in_arr[c]] : pix_in_arr[c];
      end
    end
  end

  // Read path
  wire [1:0] rd_lut_idx = lut_idx;
  wire [7:0] audio_rd   = audio_serial_ctrl_reg
                        | ({7'h00, overrun_reg} << OVERRUN_BIT)
                        | ({7'h00, underrun_reg} << UNDERRUN_BIT);
  // Second port wins the read when both are set
  wire [7:0] eq_rd      = sel_p1 ? equalizer_test_p1_reg : equalizer_test_p0_reg;
  wire [7:0] rd_mux =
      hit_color ? color_balance_ctrl_reg :
      page_lut  ? lut_mem[rd_lut_idx][reg_addr_in] :
      hit_audio ? audio_rd :
      hit_pclk  ? pixel_clock_test_reg :
      hit_dual  ? dual_receive_ctrl_reg :
      hit_eq    ? eq_rd : READ_ZERO;

  // Read data holds until the next read strobe
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_out <= READ_ZERO;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_mux;
    end
  end

  // Link lock policy
  wire lock_any  = dual_receive_ctrl_reg[LOCK_MODE_BIT];
  wire lock_next = link_up_in && (lock_any || !video_off_in);
  wire raw_aux   = dual_receive_ctrl_reg[RAW_AUX_BIT];
  wire ext_pclk  = pixel_clock_test_reg[EXT_PCLK_BIT];
  logic lock_reg;
  logic video_en_reg;
  logic aux_reg;
  logic pclk_reg;
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      lock_reg <= 1'b0;
    end else begin
      lock_reg <= lock_next;
    end
  end

  // Video follows link_up_in and video_off_in alone, whatever the lock policy says
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      video_en_reg <= 1'b0;
    end else begin
      video_en_reg <= link_up_in && !video_off_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      aux_reg <= 1'b0;
    end else begin
      aux_reg <= raw_aux ? gpio0_sync : return_filtered_in;
    end
  end

  // Sampled clock level only; edges are as coarse as the core clock
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pclk_reg <= 1'b0;
    end else begin
      pclk_reg <= ext_pclk ? selftest_sync : recov_sync;
    end
  end

  // Outputs
  assign pix_red_out               = g_chan[0].chan_reg;
  assign pix_green_out             = g_chan[1].chan_reg;
  assign pix_blue_out              = g_chan[2].chan_reg;
  assign page_out                  = color_balance_ctrl_reg[PAGE_HI:PAGE_LO];
  assign table_refresh_allow_out   = refresh_ok;
  assign audio_rise_edge_out       = audio_serial_ctrl_reg[RISE_EDGE_BIT];
  assign pixel_clk_sel_out         = ext_pclk;
  assign pixel_clk_out             = pclk_reg;
  assign rx_lock_out               = lock_reg;
  assign video_enable_out          = video_en_reg;
  assign raw_aux_return_path_out   = raw_aux;
  assign aux_return_out            = aux_reg;
  assign serial_input_mode_out     = dual_receive_ctrl_reg[INMODE_HI:INMODE_LO];
  assign second_port_access_out    = sel_p1;
  assign first_port_access_out     = sel_p0;
  assign adaptive_equalizer_p0_out = equalizer_test_p0_reg[EQ_HI:EQ_LO];
  assign adaptive_equalizer_p1_out = equalizer_test_p1_reg[EQ_HI:EQ_LO];
endmodule : dpa_regs

// >>> tb/dpa_regs_asserts.sv
// Concurrent checks on the register group ports
`timescale 1ns/1ps
module dpa_regs_asserts (
  // Clock, reset and register port
  input wire logic       core_clk_in,
  input wire logic       arst_n_in,
  input wire logic       reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  // Link status
  input wire logic       link_up_in,
  input wire logic       video_off_in,
  // Control outputs
  input wire logic [1:0] page_out,
  input wire logic       table_refresh_allow_out,
  input wire logic       audio_rise_edge_out,
  input wire logic       pixel_clk_sel_out,
  input wire logic       rx_lock_out,
  input wire logic       video_enable_out,
  input wire logic       raw_aux_return_path_out,
  input wire logic [1:0] serial_input_mode_out,
  input wire logic       second_port_access_out,
  input wire logic       first_port_access_out,
  input wire logic [2:0] adaptive_equalizer_p0_out,
  input wire logic [2:0] adaptive_equalizer_p1_out
);
  // Internal reset lifts two edges after release, so hold checks off for three edges
  logic [1:0] up_reg;
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      up_reg <= 2'h0;
    end else if (up_reg != 2'h3) begin
      up_reg <= up_reg + 2'h1;
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (up_reg != 2'h3);
  sequence cfg_wr(logic [7:0] a);
    reg_wr_in && page_out == 2'h0 && reg_addr_in == a;
  endsequence
  page_write_a : assert property (reg_wr_in && reg_addr_in == 8'h2a |=>
    page_out == $past(reg_wdata_in[7:6]) && table_refresh_allow_out == $past(reg_wdata_in[4]))
    else $error("page field write lost");
  edge_select_a : assert property (cfg_wr(8'h2b) |=>
    audio_rise_edge_out == $past(reg_wdata_in[0])) else $error("audio edge bit wrong");
  pclk_select_a : assert property (cfg_wr(8'h2e) |=>
    pixel_clk_sel_out == $past(reg_wdata_in[7])) else $error("pixel clock select wrong");
  input_mode_a : assert property (cfg_wr(8'h34) |=>
    {serial_input_mode_out, raw_aux_return_path_out, second_port_access_out,
     first_port_access_out} == $past({reg_wdata_in[4:3], reg_wdata_in[5], reg_wdata_in[1:0]}))
    else $error("dual receive fields wrong");
  eq_second_a : assert property (cfg_wr(8'h35) ##0 second_port_access_out |=>
    adaptive_equalizer_p1_out == $past(reg_wdata_in[6:4])) else $error("port one copy missed");
  eq_first_a : assert property (cfg_wr(8'h35) ##0 first_port_access_out |=>
    adaptive_equalizer_p0_out == $past(reg_wdata_in[6:4])) else $error("port zero copy missed");
  lock_active_a : assert property (link_up_in && !video_off_in |=>
    rx_lock_out && video_enable_out) else $error("lock missing with active video");
  lock_down_a : assert property (!link_up_in |=> !rx_lock_out)
    else $error("lock without link");
endmodule : dpa_regs_asserts

// >>> tb/dpa_host.sv
// Host register master model for the control slave port
`timescale 1ns/1ps
module dpa_host (
  // Clock
  input  wire logic       core_clk_in,
  // Register request
  output logic            reg_wr_out,
  output logic            reg_rd_out,
  output logic      [7:0] reg_addr_out,
  output logic      [7:0] reg_wdata_out
);
  initial begin
    {reg_wr_out, reg_rd_out, reg_addr_out, reg_wdata_out} = 18'h0;
  end
  // Entered at a falling edge; request held over exactly one rising edge
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    {reg_wr_out, reg_rd_out, reg_addr_out, reg_wdata_out} = {w, !w, a, d};
    @(negedge core_clk_in);
    // Idle bus shows the inverse, never a stale copy
    {reg_wr_out, reg_rd_out, reg_addr_out, reg_wdata_out} = {2'h0, ~a, ~d};
    @(negedge core_clk_in);
  endtask : access
endmodule : dpa_host

// >>> tb/dpa_regs_test.sv
// Self-checking bench for the port, audio and colour register group
`timescale 1ns/1ps
module dpa_regs_test;
  logic core_clk_in, arst_n_in, reg_wr_in, reg_rd_in, fifo_overrun_in, fifo_underrun_in;
  logic link_up_in, video_off_in, return_gpio_zero_in, selftest_clock_pin_in, rx_lock_out;
  logic recovered_clk_in, return_filtered_in, table_refresh_allow_out, audio_rise_edge_out;
  logic pixel_clk_sel_out, pixel_clk_out, video_enable_out, aux_return_out;
  logic raw_aux_return_path_out, second_port_access_out, first_port_access_out;
  logic [1:0] page_out, serial_input_mode_out;
  logic [2:0] adaptive_equalizer_p0_out, adaptive_equalizer_p1_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, pix_red_in, pix_green_in, pix_blue_in;
  logic [7:0] pix_red_out, pix_green_out, pix_blue_out, idx, tv [1:3], exp_q [$];
  logic [31:0] seed = 32'h2f904dd1;
  logic rd_d1 = 1'b0, rd_d2 = 1'b0;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  localparam logic [7:0] RA [5] = '{8'h2a, 8'h2b, 8'h2e, 8'h34, 8'h35};
  localparam logic [7:0] RV [5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
  localparam logic [7:0] WM [5] = '{8'hf0, 8'h01, 8'h80, 8'h7b, 8'h70};
  dpa_regs u_dpa_regs (.*);
  dpa_host u_dpa_host (.core_clk_in, .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in),
    .reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in));
  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_dpa_host.access(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_dpa_host.access(1'b0, a, 8'h00);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask : tick
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  // Read data is judged one and a half cycles after the taking edge
  always @(posedge core_clk_in) begin
    rd_d1 <= reg_rd_in;
    rd_d2 <= rd_d1;
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_mismatch++;
      test_done();
    end
  end
  always @(negedge core_clk_in) begin
    if (rd_d2) chk(reg_rdata_out, exp_q.pop_front());
  end
  initial begin
    arst_n_in = 1'b0;
    {fifo_overrun_in, fifo_underrun_in, link_up_in, video_off_in} = 4'h0;
    {return_gpio_zero_in, selftest_clock_pin_in, recovered_clk_in, return_filtered_in} = 4'h0;
    {pix_red_in, pix_green_in, pix_blue_in} = 24'h0;
    tick(3);
    arst_n_in = 1'b1;
    tick(3);
    chk({6'h0, second_port_access_out, first_port_access_out}, 8'h01);
    for (int i = 4; i >= 0; i--) begin
      rd(RA[i], RV[i]);
      wr(RA[i], 8'hff);
      rd(RA[i], WM[i]);
    end
    chk({2'h0, adaptive_equalizer_p1_out, adaptive_equalizer_p0_out}, 8'h07);
    chk({page_out, table_refresh_allow_out, audio_rise_edge_out, pixel_clk_sel_out,
         raw_aux_return_path_out, serial_input_mode_out}, 8'hff);
    idx = rnd() | 8'h01;
    for (int p = 1; p < 4; p++) begin
      wr(8'h2a, {p[1:0], 6'h10});
      chk({6'h0, page_out}, 8'(p));
      tv[p] = rnd();
      wr(idx, tv[p]);
      rd(idx, tv[p]);
      wr(8'h2a, {p[1:0], 6'h00});
      wr(idx, ~tv[p]);
      rd(idx, tv[p]);
    end
    wr(8'h2a, 8'h20);
    {pix_red_in, pix_green_in, pix_blue_in} = {3{idx}};
    tick(1);
    chk(pix_red_out, tv[1]);
    chk(pix_green_out, tv[2]);
    chk(pix_blue_out, tv[3]);
    wr(8'h2a, 8'h00);
    pix_red_in = rnd();
    tick(1);
    chk(pix_red_out, pix_red_in);
    wr(8'h2b, 8'h02);
    chk({7'h0, audio_rise_edge_out}, 8'h00);
    fifo_overrun_in = 1'b1;
    tick(1);
    fifo_overrun_in = 1'b0;
    rd(8'h2b, 8'h08);
    fifo_underrun_in = 1'b1;
    tick(1);
    fifo_underrun_in = 1'b0;
    rd(8'h2b, 8'h0c);
    wr(8'h2b, 8'h03);
    rd(8'h2b, 8'h01);
    fork
      wr(8'h2b, 8'h03);
      begin
        fifo_overrun_in = 1'b1;
        tick(1);
        fifo_overrun_in = 1'b0;
      end
    join
    rd(8'h2b, 8'h09);
    for (int i = 0; i < 8; i++) begin
      wr(8'h34, {1'b0, i[2], 1'b0, i[1:0], 3'h1});
      {link_up_in, video_off_in} = i[1:0];
      tick(2);
      chk({6'h0, rx_lock_out, video_enable_out},
          {6'h0, i[1] & (i[2] | !i[0]), i[1] & !i[0]});
      chk({6'h0, serial_input_mode_out}, {6'h0, i[1:0]});
    end
    for (int j = 0; j < 4; j++) begin
      idx = rnd();
      {return_gpio_zero_in, return_filtered_in} = {idx[0], !idx[0]};
      {selftest_clock_pin_in, recovered_clk_in} = {idx[1], !idx[1]};
      wr(8'h34, {2'h0, j[0], 5'h01});
      wr(8'h2e, {j[1], 7'h00});
      tick(2);
      chk({6'h0, aux_return_out, pixel_clk_out},
          {6'h0, idx[0] ^ !j[0], idx[1] ^ !j[1]});
    end
    wr(8'h34, 8'h02);
    chk({6'h0, second_port_access_out, first_port_access_out}, 8'h02);
    wr(8'h35, 8'h50);
    chk({2'h0, adaptive_equalizer_p1_out, adaptive_equalizer_p0_out}, 8'h2f);
    rd(8'h35, 8'h50);
    wr(8'h34, 8'h03);
    wr(8'h35, 8'h30);
    rd(8'h35, 8'h30);
    wr(8'h34, 8'h02);
    wr(8'h35, 8'h60);
    wr(8'h34, 8'h03);
    rd(8'h35, 8'h60);
    wr(8'h34, 8'h01);
    rd(8'h35, 8'h30);
    wr(8'h30, 8'hff);
    rd(8'h30, 8'h00);
    tick(3);
    test_done();
  end
endmodule : dpa_regs_test
bind dpa_regs dpa_regs_asserts u_dpa_regs_asserts (.core_clk_in, .arst_n_in, .reg_wr_in,
  .reg_addr_in, .reg_wdata_in, .link_up_in, .video_off_in, .page_out, .table_refresh_allow_out,
  .audio_rise_edge_out, .pixel_clk_sel_out, .rx_lock_out, .video_enable_out,
  .raw_aux_return_path_out, .serial_input_mode_out, .second_port_access_out,
  .first_port_access_out, .adaptive_equalizer_p0_out, .adaptive_equalizer_p1_out);
